//--- inc/adc_clk_if.sv
// Purpose: link between converter clocking device and its controller
// Assumes: one clock; register port is a simple request/ack strobe pair
// Notes:   reqWr/reqAddr/reqData held until ack
`timescale 1ns/100ps
interface adc_clk_if;
  logic        reqValid;    // Register request
  logic        reqWr;       // 1 write, 0 read
  logic [11:0] reqAddr;     // Register index
  logic [7:0]  reqData;     // Write data
  logic        ack;         // One-cycle answer
  logic [7:0]  rdData;      // Read data, valid with ack
  logic        markIn;      // Event mark, asynchronous
  logic        refOut;      // Reference clock output level
  logic        refOutOn;    // Reference output powered
  logic        trigger_clock_output;     // Trigger output level
  logic        trigOutOn;   // Trigger output powered
  logic        auxC;        // Aux output C
  logic        auxD;        // Aux output D
  logic        sampleValid; // Link sample strobe
  logic [11:0] sampleWord;  // Link sample word
  modport device (input reqValid, reqWr, reqAddr, reqData, markIn,
                  output ack, rdData, refOut, refOutOn, trigger_clock_output, trigOutOn,
                  auxC, auxD, sampleValid, sampleWord);
  modport host   (output reqValid, reqWr, reqAddr, reqData, markIn,
                  input ack, rdData, refOut, refOutOn, trigger_clock_output, trigOutOn,
                  auxC, auxD, sampleValid, sampleWord);
endinterface : adc_clk_if

//--- inc/adc_clk_pkg.sv
// Purpose: shared constants for the converter clocking and event-mark blocks
// Assumes: 8-bit device registers on a 12-bit index, 32-bit APB on the controller
// Notes:   device register offsets are indices, not byte addresses
package adc_clk_pkg;
  // ==========================================================
  // Device register map (index space)
  localparam logic [11:0] REG_NOISE_CTRL   = 12'h002B;
  localparam logic [11:0] REG_PLL_PV_DIV   = 12'h003D;
  localparam logic [11:0] REG_PLL_N_DIV    = 12'h003E;
  localparam logic [11:0] REG_PLL_HOLD     = 12'h005C;
  localparam logic [11:0] REG_VCO_TUNE_EN  = 12'h005D;
  localparam logic [11:0] REG_VCO_TUNE_FIN = 12'h005E;
  localparam logic [11:0] REG_TRIG_CTRL    = 12'h0060;
  localparam logic [11:0] REG_MISC_CTRL    = 12'h0061;
  localparam logic [11:0] REG_PLL_LOCK     = 12'h0208;
  // ==========================================================
  // Device reset values
  localparam logic [7:0] RST_NOISE  = 8'h00;
  localparam logic [7:0] RST_PV_DIV = 8'h05;
  localparam logic [7:0] RST_N_DIV  = 8'h08;
  localparam logic [7:0] RST_HOLD   = 8'h01;
  localparam logic [7:0] RST_TRIG   = 8'h00;
  localparam logic [7:0] RST_MISC   = 8'h01;
  // ==========================================================
  // Trigger control fields: [0]=enable, [2:1]=source mode, [7:3]=divider
  localparam int          TRIG_EN_BIT   = 0;
  localparam int          TRIG_MODE_LSB = 1;
  localparam int          TRIG_DIV_LSB  = 3;
  localparam logic [1:0]  TRIG_MODE_SERDES = 2'h1;
  localparam logic [1:0]  TRIG_MODE_MARK   = 2'h3;
  // Misc control: [0]=ref out enable, [1]=mark receiver enable, [2]=insertion enable,
  // [4:3]=aux C divider mode, [6:5]=aux D mode, [7]=aux override
  localparam int MISC_REFO_BIT  = 0;
  localparam int MISC_RECV_BIT  = 1;
  localparam int MISC_INS_BIT   = 2;
  localparam int MISC_AUXC_LSB  = 3;
  localparam int MISC_AUXD_LSB  = 5;
  localparam int MISC_AUXOV_BIT = 7;
  // ==========================================================
  // Timing
  localparam int VCO_TUNE_CYCLES = 16;
  localparam int LOCK_CYCLES     = 8;
  localparam int SAMPLE_LATENCY  = 3;
  localparam int SAMPLE_WIDTH    = 12;
  // ==========================================================
  // Controller APB map (byte addresses)
  localparam logic [7:0] APB_CMD    = 8'h00;
  localparam logic [7:0] APB_WDATA  = 8'h04;
  localparam logic [7:0] APB_RDATA  = 8'h08;
  localparam logic [7:0] APB_STATUS = 8'h0C;
  localparam logic [7:0] APB_PLLCFG = 8'h10;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_WR_BIT   = 12;
  localparam int CMD_GO_BIT   = 13;
  localparam int CMD_SEQ_BIT  = 14;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_TUNED_BIT = 1;
  localparam int ST_LOCK_BIT  = 2;
  localparam int ST_ERR_BIT   = 3;
endpackage : adc_clk_pkg

//--- tb/adc_clk_chk.sv
// Purpose: link checks between the clocking device and its controller
// Assumes: one clock, rst synchronous and active high
// Notes:   helper flags follow register writes seen on the link
`timescale 1ns/100ps
module adc_clk_chk
  import adc_clk_pkg::*;
(
  input wire logic        clk,         // Clock
  input wire logic        rst,         // Reset
  input wire logic        reqValid,    // Request
  input wire logic        reqWr,       // Write
  input wire logic [11:0] reqAddr,     // Index
  input wire logic [7:0]  reqData,     // Write data
  input wire logic        ack,         // Answer
  input wire logic [7:0]  rdData,      // Read data
  input wire logic        markIn,      // Event mark
  input wire logic        trigOutOn,   // Trigger powered
  input wire logic        sampleValid, // Sample strobe
  input wire logic [11:0] sampleWord   // Sample word
);
  logic       trigSeen_r;
  logic       insOn_r;
  logic [3:0] insCnt_r;
  wire        miscWr = reqValid && reqWr && reqAddr == REG_MISC_CTRL;
  function automatic logic mapped(input logic [11:0] a);
    return a inside {REG_NOISE_CTRL, REG_PLL_PV_DIV, REG_PLL_N_DIV, REG_PLL_HOLD,
                     REG_VCO_TUNE_EN, REG_VCO_TUNE_FIN, REG_TRIG_CTRL, REG_MISC_CTRL,
                     REG_PLL_LOCK};
  endfunction : mapped
  // ==========================================================
  // Helpers
  always_ff @(posedge clk) begin
    if (rst) trigSeen_r <= 1'b0;
    else if (reqValid && reqWr && reqAddr == REG_TRIG_CTRL && reqData[TRIG_EN_BIT])
      trigSeen_r <= 1'b1;
  end
  always_ff @(posedge clk) begin
    if (rst) insOn_r <= 1'b0;
    else if (miscWr) insOn_r <= reqData[MISC_RECV_BIT] && reqData[MISC_INS_BIT];
  end
  // Counter guards against words still in flight from before the change
  always_ff @(posedge clk) begin
    if (rst || !insOn_r) insCnt_r <= 4'h0;
    else if (insCnt_r != 4'hF) insCnt_r <= insCnt_r + 4'h1;
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_open; reqValid && !ack; endsequence
  sequence s_answer; ack ##1 !ack; endsequence
  property p_ack_next; s_open |=> s_answer; endproperty
  property p_ack_cause; ack |-> $past(reqValid); endproperty
  property p_hold; s_open |=> $stable(reqAddr) && $stable(reqWr) && $stable(reqData); endproperty
  property p_unmapped; ack && !$past(reqWr) && !mapped($past(reqAddr)) |-> rdData == 8'h00;
  endproperty
  property p_trig_off; !trigSeen_r |-> !trigOutOn; endproperty
  property p_trig_clr;
    reqValid && reqWr && reqAddr == REG_TRIG_CTRL && !reqData[TRIG_EN_BIT] |-> ##[1:4] !trigOutOn;
  endproperty
  property p_mark_lsb; insCnt_r == 4'hF |-> sampleWord[0] == $past(markIn, 6); endproperty
  property p_valid; !$past(rst) |-> sampleValid; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_hold: assert property (p_hold) else $error("request changed before ack");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_trig_off: assert property (p_trig_off) else $error("trigger on before enable");
  a_trig_clr: assert property (p_trig_clr) else $error("trigger stays on");
  a_mark_lsb: assert property (p_mark_lsb) else $error("mark bit wrong");
  a_valid: assert property (p_valid) else $error("sample strobe low");
endmodule : adc_clk_chk

//--- tb/adc_clocking_and_timestamp_test.sv
// Purpose: APB-driven test of the clocking device and its controller
// Assumes: 10 MHz clock, 12-cycle reset, zero-wait APB slave
// Notes:   toggle counts stand in for clock output frequency checks
`timescale 1ns/100ps
module adc_clocking_and_timestamp_test;
  import adc_clk_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, d8;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdw;
  logic        pready, pslverr, lastErr, sysCap;
  logic        eventMark = 1'b0, pllEn = 1'b1, refSe = 1'b0, pd = 1'b0, sysref = 1'b0;
  logic        diffClk = 1'b0, seRef = 1'b0, serdesClk = 1'b0;
  logic [1:0]  auxCfg = 2'b00;
  logic [11:0] adcSample = 12'h5A4;
  logic [11:0] ra[7] = '{REG_PLL_PV_DIV, REG_PLL_N_DIV, REG_PLL_HOLD, REG_TRIG_CTRL,
                         REG_MISC_CTRL, REG_VCO_TUNE_FIN, 12'h0123};
  logic [7:0]  re[7] = '{RST_PV_DIV, RST_N_DIV, RST_HOLD, RST_TRIG, RST_MISC, 8'h00, 8'h00};
  int          mismatches = 0, n_checks = 0, cyc = 0, tog[4];
  adc_clk_if lnk ();
  adc_clk_device u_adc_clk_device (.clk(clk), .rst(rst), .lnk(lnk), .pllEnStrap(pllEn),
    .refSeStrap(refSe), .auxCfgStraps(auxCfg), .powerDownPin(pd), .diffClkIn(diffClk),
    .seRefIn(seRef), .sysrefIn(sysref), .adcSample(adcSample), .serdesClkIn(serdesClk),
    .sysrefCaptured(sysCap));
  adc_clk_host u_adc_clk_host (.clk(clk), .rst(rst), .lnk(lnk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eventMark(eventMark));
  adc_clk_chk u_adc_clk_chk (.clk(clk), .rst(rst), .reqValid(lnk.reqValid), .reqWr(lnk.reqWr),
    .reqAddr(lnk.reqAddr), .reqData(lnk.reqData), .ack(lnk.ack), .rdData(lnk.rdData),
    .markIn(lnk.markIn), .trigOutOn(lnk.trigOutOn), .sampleValid(lnk.sampleValid),
    .sampleWord(lnk.sampleWord));
  always #50 clk = ~clk;
  // ==========================================================
  // Reference levels and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    diffClk <= ~diffClk;
    serdesClk <= ~serdesClk;
    if (cyc[0]) seRef <= ~seRef;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic near(input int got, input int exp);
    n_checks++;
    if (got > exp + 1 || got < exp - 1) begin
      mismatches++;
      $display("MISMATCH %0t toggles %0d exp %0d", $time, got, exp);
    end
  endtask : near
  // ==========================================================
  // Bus tasks; one idle edge between transfers
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (k >= 50) chk(1'b0, 1'b1);
  endtask : apb
  task automatic dwait;
    int k;
    k = 0;
    do begin apb(1'b0, APB_STATUS, 32'h0, rdw); k++; end
    while (rdw[ST_BUSY_BIT] !== 1'b0 && k < 400);
    if (k >= 400) chk(1'b0, 1'b1);
  endtask : dwait
  task automatic dwr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, APB_WDATA, {24'h00_0000, d}, rdw);
    apb(1'b1, APB_CMD, 32'h0000_3000 | {20'h0_0000, a}, rdw);
    dwait();
  endtask : dwr
  task automatic drd(input logic [11:0] a, output logic [7:0] d);
    apb(1'b1, APB_CMD, 32'h0000_2000 | {20'h0_0000, a}, rdw);
    dwait();
    apb(1'b0, APB_RDATA, 32'h0, rdw);
    d = rdw[7:0];
  endtask : drd
  task automatic count_tog(input int n);
    logic [3:0] prev, now;
    tog = '{0, 0, 0, 0};
    @(posedge clk);
    prev = {lnk.auxD, lnk.auxC, lnk.trigger_clock_output, lnk.refOut};
    repeat (n) begin
      @(posedge clk);
      now = {lnk.auxD, lnk.auxC, lnk.trigger_clock_output, lnk.refOut};
      for (int i = 0; i < 4; i++) if (now[i] !== prev[i]) tog[i]++;
      prev = now;
    end
  endtask : count_tog
  // ==========================================================
  // Tests
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(lnk.trigOutOn, 1'b0);
    dwr(12'h0123, 8'hFF);
    foreach (ra[i]) begin drd(ra[i], d8); chk(d8, re[i]); end
    apb(1'b0, 8'h20, 32'h0, rdw);
    chk(lastErr, 1'b1);
    $display("test reset values done");
    dwr(REG_PLL_HOLD, 8'h01);
    dwr(REG_PLL_PV_DIV, 8'h06);
    dwr(REG_PLL_N_DIV, 8'h0A);
    drd(REG_PLL_PV_DIV, d8); chk(d8, 8'h06);
    drd(REG_PLL_N_DIV, d8); chk(d8, 8'h0A);
    dwr(REG_VCO_TUNE_EN, 8'h01);
    dwr(REG_PLL_HOLD, 8'h00);
    repeat (VCO_TUNE_CYCLES + LOCK_CYCLES + 4) @(posedge clk);
    drd(REG_VCO_TUNE_FIN, d8); chk(d8, 8'h01);
    drd(REG_PLL_LOCK, d8); chk(d8, 8'h01);
    apb(1'b1, APB_PLLCFG, 32'h0000_0805, rdw);
    apb(1'b1, APB_CMD, 32'h0000_4000, rdw);
    apb(1'b1, APB_CMD, 32'h0000_2000, rdw);
    dwait();
    apb(1'b0, APB_STATUS, 32'h0, rdw); chk(rdw[3:1], 3'b111);
    drd(REG_PLL_N_DIV, d8); chk(d8, 8'h08);
    $display("test pll sequence done");
    chk(lnk.refOutOn, 1'b1);
    count_tog(32); near(tog[0], 32);
    refSe <= 1'b1;
    repeat (8) @(posedge clk);
    count_tog(32); near(tog[0], 16);
    refSe <= 1'b0;
    for (int s = 1; s < 4; s++) begin
      auxCfg <= s[1:0];
      repeat (8) @(posedge clk);
      count_tog(32); near(tog[2], 32 >> (s - 1)); near(tog[3], 32);
    end
    $display("test clock outputs done");
    eventMark <= 1'b1;
    dwr(REG_TRIG_CTRL, 8'h07);
    repeat (10) @(posedge clk); chk(lnk.trigger_clock_output, 1'b0);
    dwr(REG_MISC_CTRL, 8'h03);
    repeat (10) @(posedge clk); chk(lnk.trigger_clock_output, 1'b1);
    eventMark <= 1'b0;
    repeat (10) @(posedge clk); chk(lnk.trigger_clock_output, 1'b0);
    dwr(REG_TRIG_CTRL, 8'h13);
    count_tog(32); near(tog[1], 16); chk(lnk.trigOutOn, 1'b1);
    pd <= 1'b1;
    repeat (8) @(posedge clk);
    count_tog(16); near(tog[0] + tog[2] + tog[3], 0);
    chk({lnk.refOutOn, lnk.trigOutOn}, 2'b00);
    pd <= 1'b0;
    dwr(REG_TRIG_CTRL, 8'h00);
    dwr(REG_MISC_CTRL, 8'h00);
    repeat (8) @(posedge clk); chk(lnk.refOutOn, 1'b0);
    dwr(REG_MISC_CTRL, 8'h01);
    pllEn <= 1'b0;
    repeat (8) @(posedge clk); chk(lnk.refOutOn, 1'b0);
    $display("test trigger and power done");
    eventMark <= 1'b1;
    dwr(REG_MISC_CTRL, 8'h03);
    repeat (10) @(posedge clk); chk(lnk.sampleWord, 12'h5A4);
    dwr(REG_MISC_CTRL, 8'h07);
    repeat (10) @(posedge clk); chk(lnk.sampleWord, 12'h5A5);
    eventMark <= 1'b0;
    adcSample <= 12'h3FF;
    repeat (10) @(posedge clk); chk(lnk.sampleWord, 12'h3FE);
    sysref <= 1'b1;
    repeat (6) @(posedge clk); chk(sysCap, 1'b1);
    $display("test samples done");
    tally_and_finish();
  end
endmodule : adc_clocking_and_timestamp_test

//--- verilog/adc_clk_device.sv
// Purpose: converter clock selection, PLL sequencing, clock outputs, event mark
// Assumes: clk is the sampling clock; reference clocks arrive as sampled levels
// Notes:   analog PLL and VCO modelled by counters
// Operation
// - Mark retimed to trigger when enabled, mode 3
// - Insertion puts mark in sample LSB
// - 12-bit word: sample[11:1], mark bit 0
// - Async mark sampled, matched sample latency
// - Controller enables mark receiver first
// - PLL strap selects PLL or direct clock
// - Reference strap picks single-ended or differential
// - Single-ended input unused with PLL off; here the strap still routes it to the aux outputs
// - Ref output auto-on with PLL, bit disables
// - Power-down kills every clock output
// - Aux outputs copy/divide reference per straps
// - Ref output repeats selected reference undivided
// - One sampling clock for core and serializer
// - Serializer trigger is line rate over divider
// - Trigger off at startup; control selects source
// - Sampling rate equals reference times N
// - Controller picks legal VCO divisor
// - Hold PLL in reset before reprogramming
// - Dividers at two adjacent registers
// - Tuning runs on release from reset
// - Tune-done and lock readable
// - System reference captured on selected input
`timescale 1ns/100ps
module adc_clk_device
  import adc_clk_pkg::*;
#(
  parameter int TUNE_CYCLES = VCO_TUNE_CYCLES,  // VCO tuning time
  parameter int LOCKCYCLES  = LOCK_CYCLES       // Lock settle time
) (
  input  wire logic              clk,           // Sampling clock
  input  wire logic              rst,           // Sync reset, high
  adc_clk_if.device              lnk,           // Link to controller
  input  wire logic              pllEnStrap,    // PLL enable strap
  input  wire logic              refSeStrap,    // Single-ended ref select strap
  input  wire logic [1:0]        auxCfgStraps,  // Aux clock config straps
  input  wire logic              powerDownPin,  // Power-down pin
  input  wire logic              diffClkIn,     // Differential clock level
  input  wire logic              seRefIn,       // Single-ended ref level
  input  wire logic              sysrefIn,      // System reference
  input  wire logic [11:0]       adcSample,     // Converter sample
  input  wire logic              serdesClkIn,   // Serializer line clock level
  output logic                   sysrefCaptured // Captured system reference
);
  // ==========================================================
  // Pin synchronisers
  logic [1:0] markS, pdS, pllS, seS, diffS, seRefS, srS, serS;
  logic [1:0] auxS0, auxS1;
  always_ff @(posedge clk) begin
    markS  <= {markS[0], lnk.markIn};
    pdS    <= {pdS[0], powerDownPin};
    pllS   <= {pllS[0], pllEnStrap};
    seS    <= {seS[0], refSeStrap};
    diffS  <= {diffS[0], diffClkIn};
    seRefS <= {seRefS[0], seRefIn};
    srS    <= {srS[0], sysrefIn};
    serS   <= {serS[0], serdesClkIn};
    auxS0  <= {auxS0[0], auxCfgStraps[0]};
    auxS1  <= {auxS1[0], auxCfgStraps[1]};
  end
  wire logic pd     = pdS[1];
  wire logic pllOn  = pllS[1];
  wire logic refSe  = seS[1];
  // ==========================================================
  // Registers
  logic [7:0] noise_r, pvDiv_r, nDiv_r, hold_r, tuneEn_r, trig_r, misc_r;
  logic       tuneFin_r, locked_r;
  logic [15:0] tuneCnt_r;
  logic [7:0]  lockCnt_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      noise_r  <= RST_NOISE;
      pvDiv_r  <= RST_PV_DIV;
      nDiv_r   <= RST_N_DIV;
      hold_r   <= RST_HOLD;
      tuneEn_r <= 8'h00;
      trig_r   <= RST_TRIG;
      misc_r   <= RST_MISC;
    end else if (lnk.reqValid && lnk.reqWr) begin
      case (lnk.reqAddr)
        REG_NOISE_CTRL:  noise_r  <= lnk.reqData;
        REG_PLL_PV_DIV:  pvDiv_r  <= lnk.reqData;
        REG_PLL_N_DIV:   nDiv_r   <= lnk.reqData;
        REG_PLL_HOLD:    hold_r   <= lnk.reqData;
        REG_VCO_TUNE_EN: tuneEn_r <= lnk.reqData;
        REG_TRIG_CTRL:   trig_r   <= lnk.reqData;
        REG_MISC_CTRL:   misc_r   <= lnk.reqData;
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    lnk.ack <= lnk.reqValid && !lnk.ack;
    case (lnk.reqAddr)
      REG_NOISE_CTRL:   lnk.rdData <= noise_r;
      REG_PLL_PV_DIV:   lnk.rdData <= pvDiv_r;
      REG_PLL_N_DIV:    lnk.rdData <= nDiv_r;
      REG_PLL_HOLD:     lnk.rdData <= hold_r;
      REG_VCO_TUNE_EN:  lnk.rdData <= tuneEn_r;
      REG_VCO_TUNE_FIN: lnk.rdData <= {7'h00, tuneFin_r};
      REG_TRIG_CTRL:    lnk.rdData <= trig_r;
      REG_MISC_CTRL:    lnk.rdData <= misc_r;
      REG_PLL_LOCK:     lnk.rdData <= {7'h00, locked_r};
      default:          lnk.rdData <= 8'h00;
    endcase
    if (rst) begin
      lnk.ack    <= 1'b0;
      lnk.rdData <= 8'h00;
    end
  end
  // ==========================================================
  // PLL sequencing: tune starts when hold released with tune enabled
  wire logic holdNow = hold_r[0] || !pllOn;
  always_ff @(posedge clk) begin
    if (rst || holdNow) begin
      tuneFin_r <= 1'b0;
      locked_r  <= 1'b0;
      tuneCnt_r <= 16'h0000;
      lockCnt_r <= 8'h00;
    end else if (!tuneFin_r) begin
      if (tuneEn_r[0]) begin
        if (tuneCnt_r == 16'(TUNE_CYCLES - 1)) tuneFin_r <= 1'b1;
        else tuneCnt_r <= tuneCnt_r + 16'h0001;
      end
    end else if (!locked_r) begin
      if (lockCnt_r == 8'(LOCKCYCLES - 1)) locked_r <= 1'b1;
      else lockCnt_r <= lockCnt_r + 8'h01;
    end
  end
  // ==========================================================
  // Clock outputs
  wire logic selRef = refSe ? seRefS[1] : diffS[1];
  // Counts half periods: bit 0 tracks the level, bit 1 is /2, bit 2 is /4
  logic [2:0] refDiv_r;
  logic       serPrev_r, trigClk_r;
  logic [4:0] serCnt_r;
  always_ff @(posedge clk) begin
    if (rst) refDiv_r <= 3'b000;
    else if (selRef != refDiv_r[0]) refDiv_r <= refDiv_r + 3'b001;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      serPrev_r <= 1'b0;
      serCnt_r  <= 5'h00;
      trigClk_r <= 1'b0;
    end else begin
      serPrev_r <= serS[1];
      // Both line-clock edges counted so an odd divider still divides exactly
      if (serS[1] != serPrev_r) begin
        if (serCnt_r + 5'h01 >= trig_r[TRIG_DIV_LSB +: 5]) begin
          serCnt_r  <= 5'h00;
          trigClk_r <= !trigClk_r;
        end else serCnt_r <= serCnt_r + 5'h01;
      end
    end
  end
  function automatic logic auxSel(input logic [1:0] m, input logic r, input logic [1:0] d);
    case (m)
      2'h1:    auxSel = r;
      2'h2:    auxSel = d[0];
      2'h3:    auxSel = d[1];
      default: auxSel = 1'b0;
    endcase
  endfunction : auxSel
  wire logic [1:0] cfg   = {auxS1[1], auxS0[1]};
  wire logic [1:0] modeC = misc_r[MISC_AUXOV_BIT] ? misc_r[MISC_AUXC_LSB +: 2] : cfg;
  wire logic [1:0] modeD = misc_r[MISC_AUXOV_BIT] ? misc_r[MISC_AUXD_LSB +: 2]
                         : ((cfg != 2'h0) ? 2'h1 : 2'h0);
  wire logic [1:0] trigMode = trig_r[TRIG_MODE_LSB +: 2];
  logic [SAMPLE_LATENCY-1:0] markPipe_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      lnk.refOut    <= 1'b0;
      lnk.refOutOn  <= 1'b0;
      lnk.auxC      <= 1'b0;
      lnk.auxD      <= 1'b0;
      lnk.trigger_clock_output   <= 1'b0;
      lnk.trigOutOn <= 1'b0;
    end else begin
      lnk.refOutOn  <= pllOn && !pd && misc_r[MISC_REFO_BIT];
      lnk.refOut    <= pllOn && !pd && misc_r[MISC_REFO_BIT] && selRef;
      lnk.auxC      <= !pd && auxSel(modeC, selRef, refDiv_r[2:1]);
      lnk.auxD      <= !pd && (modeC != 2'h0) && auxSel(modeD, selRef, refDiv_r[2:1]);
      lnk.trigOutOn <= !pd && trig_r[TRIG_EN_BIT];
      if (pd || !trig_r[TRIG_EN_BIT]) lnk.trigger_clock_output <= 1'b0;
      else if (trigMode == TRIG_MODE_MARK)
        lnk.trigger_clock_output <= misc_r[MISC_RECV_BIT] && markS[1];
      else if (trigMode == TRIG_MODE_SERDES) lnk.trigger_clock_output <= trigClk_r;
      else lnk.trigger_clock_output <= 1'b0;
    end
  end
  // ==========================================================
  // Sample path with matched mark latency
  logic [11:0] smpPipe_r [SAMPLE_LATENCY];
  always_ff @(posedge clk) begin
    if (rst) begin
      markPipe_r <= '0;
      for (int i = 0; i < SAMPLE_LATENCY; i++) smpPipe_r[i] <= 12'h000;
    end else begin
      markPipe_r   <= {markPipe_r[SAMPLE_LATENCY-2:0], markS[1] && misc_r[MISC_RECV_BIT]};
      smpPipe_r[0] <= adcSample;
      for (int i = 1; i < SAMPLE_LATENCY; i++) smpPipe_r[i] <= smpPipe_r[i-1];
    end
  end
  wire logic [11:0] lastSmp = smpPipe_r[SAMPLE_LATENCY-1];
  always_ff @(posedge clk) begin
    if (rst) begin
      lnk.sampleValid <= 1'b0;
      lnk.sampleWord  <= 12'h000;
      sysrefCaptured  <= 1'b0;
    end else begin
      lnk.sampleValid <= 1'b1;
      if (misc_r[MISC_INS_BIT])
        lnk.sampleWord <= {lastSmp[11:1], markPipe_r[SAMPLE_LATENCY-1]};
      else lnk.sampleWord <= lastSmp;
      sysrefCaptured <= srS[1];
    end
  end
endmodule : adc_clk_device

//--- verilog/adc_clk_host.sv
// Purpose: controller end; APB registers drive device register accesses
// Assumes: APB slave, zero wait states, 32-bit data
// Notes:   sequence bit runs the PLL reprogram and tune steps
`timescale 1ns/100ps
module adc_clk_host
  import adc_clk_pkg::*;
(
  input  wire logic        clk,       // System clock
  input  wire logic        rst,       // Sync reset, high
  adc_clk_if.host          lnk,       // Link to device
  input  wire logic        psel,      // APB select
  input  wire logic        penable,   // APB enable
  input  wire logic        pwrite,    // APB write
  input  wire logic [7:0]  paddr,     // APB address
  input  wire logic [31:0] pwdata,    // APB write data
  output logic [31:0]      prdata,    // APB read data
  output logic             pready,    // APB ready
  output logic             pslverr,   // APB error
  input  wire logic        eventMark  // Event mark to forward
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_SINGLE = 5'b00010, S_SEQ = 5'b00100,
    S_WAIT = 5'b01000, S_POLL = 5'b10000
  } state_e;
  state_e st_r;
  logic [31:0] cmd_r, wdata_r, rdata_r, pllCfg_r;
  logic [2:0]  step_r;
  logic        err_r, tuned_r, lockd_r;
  wire logic apbWr = psel && penable && pwrite;
  wire logic busy  = (st_r != S_IDLE);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(paddr == APB_CMD || paddr == APB_WDATA
                  || paddr == APB_RDATA || paddr == APB_STATUS || paddr == APB_PLLCFG);
  always_comb begin
    case (paddr)
      APB_CMD:    prdata = cmd_r;
      APB_WDATA:  prdata = wdata_r;
      APB_RDATA:  prdata = rdata_r;
      APB_STATUS: prdata = {28'h000_0000, err_r, lockd_r, tuned_r, busy};
      APB_PLLCFG: prdata = pllCfg_r;
      default:    prdata = 32'h0000_0000;
    endcase
  end
  // Step list: hold, P/V, N, tune enable, release, poll done, poll lock
  always_comb begin
    lnk.reqWr   = 1'b1;
    lnk.reqAddr = REG_PLL_HOLD;
    lnk.reqData = 8'h01;
    if (st_r == S_SINGLE) begin
      lnk.reqWr   = cmd_r[CMD_WR_BIT];
      lnk.reqAddr = cmd_r[CMD_ADDR_LSB +: 12];
      lnk.reqData = wdata_r[7:0];
    end else begin
      case (step_r)
        3'd0: lnk.reqData = 8'h01;
        3'd1: begin lnk.reqAddr = REG_PLL_PV_DIV; lnk.reqData = pllCfg_r[7:0]; end
        3'd2: begin lnk.reqAddr = REG_PLL_N_DIV;  lnk.reqData = pllCfg_r[15:8]; end
        3'd3: begin lnk.reqAddr = REG_VCO_TUNE_EN; lnk.reqData = 8'h01; end
        3'd4: lnk.reqData = 8'h00;
        3'd5: begin lnk.reqWr = 1'b0; lnk.reqAddr = REG_VCO_TUNE_FIN; end
        default: begin lnk.reqWr = 1'b0; lnk.reqAddr = REG_PLL_LOCK; end
      endcase
    end
  end
  assign lnk.reqValid = (st_r == S_SINGLE) || (st_r == S_SEQ) || (st_r == S_POLL);
  assign lnk.markIn   = eventMark;
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= S_IDLE; cmd_r <= '0; wdata_r <= '0; rdata_r <= '0;
      pllCfg_r <= 32'h0000_0805; step_r <= 3'd0;
      err_r <= 1'b0; tuned_r <= 1'b0; lockd_r <= 1'b0;
    end else begin
      if (apbWr && paddr == APB_WDATA)  wdata_r  <= pwdata;
      if (apbWr && paddr == APB_PLLCFG) pllCfg_r <= pwdata;
      if (apbWr && paddr == APB_CMD)    cmd_r    <= pwdata;
      // Command refused while busy; sticky so software can notice it late
      if (apbWr && paddr == APB_CMD && busy) err_r <= 1'b1;
      case (st_r)
        S_IDLE: if (apbWr && paddr == APB_CMD && !busy) begin
          if (pwdata[CMD_SEQ_BIT]) begin
            st_r <= S_SEQ; step_r <= 3'd0; tuned_r <= 1'b0; lockd_r <= 1'b0;
          end else if (pwdata[CMD_GO_BIT]) st_r <= S_SINGLE;
        end
        S_SINGLE: if (lnk.ack) begin
          rdata_r <= {24'h00_0000, lnk.rdData};
          st_r <= S_IDLE;
        end
        S_SEQ: if (lnk.ack) begin
          step_r <= step_r + 3'd1;
          st_r   <= (step_r == 3'd4) ? S_POLL : S_WAIT;
        end
        S_WAIT: st_r <= S_SEQ;
        S_POLL: if (lnk.ack) begin
          if (step_r == 3'd5 && lnk.rdData[0]) begin
            tuned_r <= 1'b1; step_r <= 3'd6;
          end else if (step_r == 3'd6 && lnk.rdData[0]) begin
            lockd_r <= 1'b1; st_r <= S_IDLE;
          end else st_r <= S_WAIT;
        end
        default: st_r <= S_IDLE;
      endcase
      if (st_r == S_WAIT && step_r >= 3'd5) st_r <= S_POLL;
    end
  end
endmodule : adc_clk_host
